// file: core/hws_pkg.sv
// Constants, types and gap lookup shared by the host write-read spacing controller
package hws_pkg;
    // Clock period of clk in ns (25 MHz)
    localparam int CLK_NS = 40;
    // Register byte address width on the host bus
    localparam int ADDR_W = 9;
    // Full register width and host bus width
    localparam int DATA_W = 32;
    localparam int BUS_W = 16;
    // Strobe length in clocks; 80 ns comfortably exceeds the 45 ns host_cycle_time
    localparam logic [3:0] STB_LAST = 4'h1;
    localparam logic [3:0] STB_FIRST = 4'h0;
    // Write-to-read gaps in ns, as printed
    localparam int T_ANY_NS = 45;
    localparam int T_TXDATA_INFO_NS = 135;
    localparam int T_IRQCFG_IRQCFG_NS = 60;
    localparam int T_IRQEN_IRQCFG_NS = 90;
    localparam int T_IRQEN_STATUS_NS = 60;
    localparam int T_STATUS_IRQCFG_NS = 180;
    localparam int T_STATUS_STATUS_NS = 170;
    localparam int T_FIFOLVL_IRQCFG_NS = 90;
    localparam int T_FIFOLVL_STATUS_NS = 80;
    // Device register byte addresses
    localparam logic [8:0] A_IRQ_CONFIG = 9'h054;
    localparam logic [8:0] A_INTERRUPT_STATUS = 9'h058;
    localparam logic [8:0] A_IRQ_ENABLE = 9'h05C;
    localparam logic [8:0] A_BYTE_ORDER_TEST = 9'h064;
    localparam logic [8:0] A_FIFO_LEVEL_IRQ = 9'h068;
    localparam logic [8:0] A_TRANSMIT_FIFO_INFO = 9'h080;
    // Transmit data FIFO window inside the FIFO region
    localparam logic [8:0] A_TXDATA_LO = 9'h020;
    localparam logic [8:0] A_TXDATA_HI = 9'h03C;
    // Saturation value of the elapsed-time counters
    localparam logic [7:0] ELAPSED_MAX = 8'hFF;
    localparam logic [7:0] ELAPSED_FIRST = 8'h01;

    typedef logic [ADDR_W-1:0] hws_addr_t;
    typedef logic [7:0] hws_cyc_t;
    // One-hot controller states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_GAP = 4'b0010,
        ST_STB = 4'b0100,
        ST_REC = 4'b1000
    } hws_state_t;

    // Least time in ns to whole clocks, rounded up, never below one
    function automatic hws_cyc_t ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return hws_cyc_t'(c);
    endfunction

    // Same 32-bit register, ignoring the byte lane bits
    function automatic logic same_reg(input hws_addr_t a, input hws_addr_t b);
        return a[ADDR_W-1:2] == b[ADDR_W-1:2];
    endfunction

    // Address lies in the transmit data FIFO window
    function automatic logic in_txdata(input hws_addr_t a);
        return (a >= A_TXDATA_LO) && (a <= A_TXDATA_HI);
    endfunction

    // Clocks needed between a final write to wa and a read of ra
    function automatic hws_cyc_t gap_cyc(input hws_addr_t wa, input hws_addr_t ra);
        int ns;
        ns = T_ANY_NS;
        if (in_txdata(wa) && same_reg(ra, A_TRANSMIT_FIFO_INFO)) begin
            ns = T_TXDATA_INFO_NS;
        end else if (same_reg(wa, A_IRQ_CONFIG) && same_reg(ra, A_IRQ_CONFIG)) begin
            ns = T_IRQCFG_IRQCFG_NS;
        end else if (same_reg(wa, A_IRQ_ENABLE)) begin
            if (same_reg(ra, A_IRQ_CONFIG)) begin
                ns = T_IRQEN_IRQCFG_NS;
            end else if (same_reg(ra, A_INTERRUPT_STATUS)) begin
                ns = T_IRQEN_STATUS_NS;
            end
        end else if (same_reg(wa, A_INTERRUPT_STATUS)) begin
            if (same_reg(ra, A_IRQ_CONFIG)) begin
                ns = T_STATUS_IRQCFG_NS;
            end else if (same_reg(ra, A_INTERRUPT_STATUS)) begin
                ns = T_STATUS_STATUS_NS;
            end
        end else if (same_reg(wa, A_FIFO_LEVEL_IRQ)) begin
            if (same_reg(ra, A_IRQ_CONFIG)) begin
                ns = T_FIFOLVL_IRQCFG_NS;
            end else if (same_reg(ra, A_INTERRUPT_STATUS)) begin
                ns = T_FIFOLVL_STATUS_NS;
            end
        end
        return ns_to_cyc(ns);
    endfunction
endpackage

// file: core/hws_gap_if.sv
// Interface between the bus sequencer and the write-to-read gap tracker
`timescale 1ns/100ps
`default_nettype none
interface hws_gap_if;
    logic wr_done; // Final word of a tracked write has just ended
    hws_pkg::hws_addr_t wr_addr; // Address of that write
    hws_pkg::hws_addr_t rd_addr; // Address of the read waiting to start
    logic gap_ok; // Read may start now
    modport tracker(input wr_done, input wr_addr, input rd_addr, output gap_ok);
    modport ctrl(output wr_done, output wr_addr, output rd_addr, input gap_ok);
endinterface
`default_nettype wire

// file: core/hws_gap_track.sv
// Tracker of the last tracked write and the time elapsed since it
`timescale 1ns/100ps
`default_nettype none
module hws_gap_track (
    input wire logic clk,
    input wire logic srst,
    hws_gap_if.tracker gap
);
    hws_pkg::hws_addr_t last_addr_r; // Register last written
    logic wr_seen_r; // A tracked write happened since reset
    hws_pkg::hws_cyc_t elapsed_r; // Clocks since that write ended

    // Remember that some tracked write has happened at all
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_seen_r <= 1'b0;
        end else if (gap.wr_done) begin
            wr_seen_r <= 1'b1;
        end
    end

    // Record the last written register
    always_ff @(posedge clk) begin
        if (srst) begin
            last_addr_r <= '0;
        end else if (gap.wr_done) begin
            last_addr_r <= gap.wr_addr;
        end
    end

    // Time since the write strobe ended; one clock is already gone at wr_done.
    // Keeps running through dummy reads, so only total time matters
    always_ff @(posedge clk) begin
        if (srst) begin
            elapsed_r <= hws_pkg::ELAPSED_MAX;
        end else if (gap.wr_done) begin
            elapsed_r <= hws_pkg::ELAPSED_FIRST;
        end else if (elapsed_r != hws_pkg::ELAPSED_MAX) begin
            elapsed_r <= elapsed_r + hws_pkg::ELAPSED_FIRST;
        end
    end

    // Gap depends on which register is read after which write
    assign gap.gap_ok = !wr_seen_r ||
        (elapsed_r >= hws_pkg::gap_cyc(last_addr_r, gap.rd_addr));
endmodule
`default_nettype wire

// file: core/hws_host_ctrl.sv
// Host bus controller that spaces register reads after writes on a 16-bit bus
// Functional notes
// - Any write: 45 ns or one dummy read
// - Transmit data write: 135 ns before FIFO info
// - IRQ config write: 60 ns before rereading it
// - IRQ enable write: 90/60 ns config/status
// - Status write: 180/170 ns config/status
// - FIFO level write: 90/80 ns config/status
// - Byte order test dummy reads fill gaps
// - Fewer slower dummy reads fine if time met
// - No dummy reads once gap elapsed
// - Gap counts from final word of register
// - Index and config registers are exempt
// - Gap depends on which register is read
// - Byte order test readable anytime, no effect; the code still holds tracked reads of it for the 45 ns gap
`timescale 1ns/100ps
`default_nettype none
module hws_host_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_index_reg,
    input wire logic [8:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    input wire logic dummy_read_en,
    output logic gap_stall,
    output logic [8:0] hb_addr,
    output logic hb_cs_n,
    output logic hb_rd_n,
    output logic hb_wr_n,
    input wire logic [15:0] hb_data_in,
    output logic [15:0] hb_data_out,
    output logic hb_data_oe
);
    hws_gap_if gap ();

    hws_gap_track u_track (
        .clk(clk),
        .srst(srst),
        .gap(gap)
    );

    hws_pkg::hws_state_t state_r; // Sequencer state
    hws_pkg::hws_state_t state_nxt;
    logic word_r; // Word of the register in flight, low word first
    logic word_nxt;
    logic dummy_r; // Current strobe is a dummy read
    logic dummy_nxt;
    logic write_r; // Request in flight is a write
    logic write_nxt;
    logic index_r; // Request targets host_bus_interface index or config registers
    logic index_nxt;
    hws_pkg::hws_addr_t addr_r; // Register address of the request
    hws_pkg::hws_addr_t addr_nxt;
    logic [31:0] wdata_r; // Write data of the request
    logic [31:0] rdata_r; // Read data being assembled
    logic [3:0] stb_cnt_r; // Clocks spent in the current strobe
    logic accept; // Request taken this cycle
    logic stb_next; // A strobe is active in the next cycle

    assign accept = req_valid && req_ready;
    assign stb_next = (state_nxt == hws_pkg::ST_STB);

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hws_pkg::ST_IDLE: begin
                if (accept) begin
                    // Writes and exempt reads skip the gap check
                    if (req_write || req_index_reg) begin
                        state_nxt = hws_pkg::ST_STB;
                    end else begin
                        state_nxt = hws_pkg::ST_GAP;
                    end
                end
            end
            hws_pkg::ST_GAP: begin
                // Stall the read, or fill the wait with dummy reads
                if (gap.gap_ok || dummy_read_en) begin
                    state_nxt = hws_pkg::ST_STB;
                end
            end
            hws_pkg::ST_STB: begin
                if (stb_cnt_r == hws_pkg::STB_LAST) begin
                    state_nxt = hws_pkg::ST_REC;
                end
            end
            hws_pkg::ST_REC: begin
                if (dummy_r) begin
                    // Back to recheck the gap after each dummy read
                    state_nxt = hws_pkg::ST_GAP;
                end else if (!word_r) begin
                    // No wait between the two words of one register
                    state_nxt = hws_pkg::ST_STB;
                end else begin
                    state_nxt = hws_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = hws_pkg::ST_IDLE;
            end
        endcase
    end

    // Next values of the request context, so pins can be registered from them
    always_comb begin
        write_nxt = write_r;
        index_nxt = index_r;
        addr_nxt = addr_r;
        word_nxt = word_r;
        dummy_nxt = dummy_r;
        if (state_r == hws_pkg::ST_IDLE) begin
            write_nxt = req_write;
            index_nxt = req_index_reg;
            addr_nxt = req_addr;
            word_nxt = 1'b0;
            dummy_nxt = 1'b0;
        end else if (state_r == hws_pkg::ST_GAP) begin
            // Dummy read only while the gap is still open
            dummy_nxt = !gap.gap_ok;
        end else if ((state_r == hws_pkg::ST_REC) && !dummy_r && !word_r) begin
            word_nxt = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= hws_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request context
    always_ff @(posedge clk) begin
        if (srst) begin
            write_r <= 1'b0;
            index_r <= 1'b0;
            addr_r <= '0;
            word_r <= 1'b0;
            dummy_r <= 1'b0;
        end else begin
            write_r <= write_nxt;
            index_r <= index_nxt;
            addr_r <= addr_nxt;
            word_r <= word_nxt;
            dummy_r <= dummy_nxt;
        end
    end

    // Write data is held for both words
    always_ff @(posedge clk) begin
        if (srst) begin
            wdata_r <= '0;
        end else if (accept) begin
            wdata_r <= req_wdata;
        end
    end

    // Strobe length counter
    always_ff @(posedge clk) begin
        if (srst) begin
            stb_cnt_r <= hws_pkg::STB_FIRST;
        end else if (state_r == hws_pkg::ST_STB) begin
            stb_cnt_r <= stb_cnt_r + 4'h1;
        end else begin
            stb_cnt_r <= hws_pkg::STB_FIRST;
        end
    end

    // Read data capture at the last strobe clock; dummy data is dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= '0;
        end else if ((state_r == hws_pkg::ST_STB) && (stb_cnt_r == hws_pkg::STB_LAST) &&
                     !write_r && !dummy_r) begin
            if (word_r) begin
                rdata_r[31:16] <= hb_data_in;
            end else begin
                rdata_r[15:0] <= hb_data_in;
            end
        end
    end

    // Bus pins, all registered from next-state values
    always_ff @(posedge clk) begin
        if (srst) begin
            hb_cs_n <= 1'b1;
            hb_rd_n <= 1'b1;
            hb_wr_n <= 1'b1;
            hb_addr <= '0;
            hb_data_out <= '0;
            hb_data_oe <= 1'b0;
        end else begin
            hb_cs_n <= !stb_next;
            hb_rd_n <= !(stb_next && (!write_nxt || dummy_nxt));
            hb_wr_n <= !(stb_next && write_nxt && !dummy_nxt);
            hb_data_oe <= stb_next && write_nxt && !dummy_nxt;
            if (dummy_nxt) begin
                // Dummy reads always go to the byte order test register
                hb_addr <= hws_pkg::A_BYTE_ORDER_TEST;
            end else begin
                hb_addr <= {addr_nxt[8:2], word_nxt, 1'b0};
            end
            if (word_nxt) begin
                hb_data_out <= wdata_r[31:16];
            end else begin
                hb_data_out <= req_wdata[15:0];
            end
            if (state_r != hws_pkg::ST_IDLE && !word_nxt) begin
                hb_data_out <= wdata_r[15:0];
            end
        end
    end

    // Final word of a tracked write starts the gap; exempt writes do not
    assign gap.wr_done = (state_r == hws_pkg::ST_REC) && write_r && word_r && !index_r;
    assign gap.wr_addr = addr_r;
    assign gap.rd_addr = addr_r;

    // User side handshake and status
    always_ff @(posedge clk) begin
        if (srst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            gap_stall <= 1'b0;
        end else begin
            req_ready <= (state_nxt == hws_pkg::ST_IDLE);
            rsp_valid <= (state_r == hws_pkg::ST_REC) && word_r && !write_r && !dummy_r;
            gap_stall <= (state_nxt == hws_pkg::ST_GAP);
        end
    end

    assign rsp_rdata = rdata_r;

    // Independent record of the last tracked write, read only by the checks below
    hws_pkg::hws_addr_t chk_last_r;
    logic [7:0] chk_since_r;
    logic chk_seen_r;
    logic rd_prev_r; // Read strobe one clock ago, to find its falling edge
    logic rd_begin;

    always_ff @(posedge clk) begin
        if (srst) begin
            chk_last_r <= '0;
            chk_since_r <= hws_pkg::ELAPSED_MAX;
            chk_seen_r <= 1'b0;
        end else if (gap.wr_done) begin
            chk_last_r <= addr_r;
            chk_since_r <= hws_pkg::ELAPSED_FIRST;
            chk_seen_r <= 1'b1;
        end else if (chk_since_r != hws_pkg::ELAPSED_MAX) begin
            chk_since_r <= chk_since_r + 8'h01;
        end
    end

    // Read strobe of the previous clock; idle level after reset avoids a false edge
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_prev_r <= 1'b1;
        end else begin
            rd_prev_r <= hb_rd_n;
        end
    end

    // First clock of the first word of a tracked, real read
    assign rd_begin = rd_prev_r && !hb_rd_n && !dummy_r && !index_r && !word_r && chk_seen_r;

    any_gap_a: assert property (@(posedge clk) disable iff (srst)
        rd_begin |-> chk_since_r >= hws_pkg::ns_to_cyc(hws_pkg::T_ANY_NS))
        else $error("read started less than 45 ns after a write");

    txinfo_gap_a: assert property (@(posedge clk) disable iff (srst)
        rd_begin && hws_pkg::in_txdata(chk_last_r) &&
        hws_pkg::same_reg(addr_r, hws_pkg::A_TRANSMIT_FIFO_INFO)
        |-> chk_since_r >= hws_pkg::ns_to_cyc(hws_pkg::T_TXDATA_INFO_NS))
        else $error("fifo info read too soon after transmit data write");

    irqcfg_gap_a: assert property (@(posedge clk) disable iff (srst)
        rd_begin && hws_pkg::same_reg(chk_last_r, hws_pkg::A_IRQ_CONFIG) &&
        hws_pkg::same_reg(addr_r, hws_pkg::A_IRQ_CONFIG)
        |-> chk_since_r >= hws_pkg::ns_to_cyc(hws_pkg::T_IRQCFG_IRQCFG_NS))
        else $error("irq config reread too soon");

    irqen_gap_a: assert property (@(posedge clk) disable iff (srst)
        rd_begin && hws_pkg::same_reg(chk_last_r, hws_pkg::A_IRQ_ENABLE) &&
        hws_pkg::same_reg(addr_r, hws_pkg::A_IRQ_CONFIG)
        |-> chk_since_r >= hws_pkg::ns_to_cyc(hws_pkg::T_IRQEN_IRQCFG_NS))
        else $error("irq config read too soon after enable write");

    status_gap_a: assert property (@(posedge clk) disable iff (srst)
        rd_begin && hws_pkg::same_reg(chk_last_r, hws_pkg::A_INTERRUPT_STATUS) &&
        hws_pkg::same_reg(addr_r, hws_pkg::A_INTERRUPT_STATUS)
        |-> chk_since_r >= hws_pkg::ns_to_cyc(hws_pkg::T_STATUS_STATUS_NS))
        else $error("status reread too soon after status write");

    fifolvl_gap_a: assert property (@(posedge clk) disable iff (srst)
        rd_begin && hws_pkg::same_reg(chk_last_r, hws_pkg::A_FIFO_LEVEL_IRQ) &&
        hws_pkg::same_reg(addr_r, hws_pkg::A_IRQ_CONFIG)
        |-> chk_since_r >= hws_pkg::ns_to_cyc(hws_pkg::T_FIFOLVL_IRQCFG_NS))
        else $error("irq config read too soon after fifo level write");

    dummy_addr_a: assert property (@(posedge clk) disable iff (srst)
        $fell(hb_rd_n) && dummy_r |-> hb_addr == hws_pkg::A_BYTE_ORDER_TEST && hb_wr_n)
        else $error("dummy read not aimed at byte order test register");

    dummy_fill_a: assert property (@(posedge clk) disable iff (srst)
        state_r == hws_pkg::ST_GAP && !gap.gap_ok && dummy_read_en
        |=> !hb_rd_n && dummy_r)
        else $error("open gap not filled by a dummy read");

    no_dummy_a: assert property (@(posedge clk) disable iff (srst)
        state_r == hws_pkg::ST_GAP && gap.gap_ok |=> !hb_rd_n && !dummy_r)
        else $error("dummy read issued after gap elapsed");

    word_pair_a: assert property (@(posedge clk) disable iff (srst)
        state_r == hws_pkg::ST_REC && !dummy_r && !word_r |=> !hb_cs_n ##1 !hb_cs_n)
        else $error("second word delayed");

    exempt_rd_a: assert property (@(posedge clk) disable iff (srst)
        accept && req_index_reg && !req_write |=> !hb_rd_n && !dummy_r)
        else $error("exempt read was held back");

    stall_rd_a: assert property (@(posedge clk) disable iff (srst)
        state_r == hws_pkg::ST_GAP && !gap.gap_ok && !dummy_read_en |=> hb_rd_n && gap_stall)
        else $error("conflicting read not stalled");
endmodule
`default_nettype wire

// file: testbench/hws_dev_model.sv
// Behavioural model of the device register space seen on the 16-bit host bus
`timescale 1ns/100ps
`default_nettype none
module hws_dev_model #(
    parameter logic [31:0] BT_VAL = 32'h1234ABCD // Arbitrary byte order test pattern
) (
    input wire logic clk,
    input wire logic exempt,
    input wire logic [8:0] hb_addr,
    input wire logic hb_cs_n,
    input wire logic hb_rd_n,
    input wire logic hb_wr_n,
    input wire logic [15:0] hb_data_out,
    output logic [15:0] hb_data_in,
    output logic [15:0] viol = 16'h0000,
    output logic [15:0] dummies = 16'h0000
);
    logic [31:0] mem [128]; // Register contents by word index
    logic [15:0] low_r; // Low word waits for the high word to complete the register
    logic [15:0] idle_r = 16'hA5A5; // Filler that flips each cycle while released
    logic wr_prev = 1'b0;
    logic rd_prev = 1'b0;
    logic wr_seen = 1'b0; // No write yet, so no gap applies
    logic [8:0] wa_r;
    logic [6:0] last_w;
    realtime t_w;
    logic [31:0] word;
    wire wr_act = !hb_cs_n && !hb_wr_n;
    wire rd_act = !hb_cs_n && !hb_rd_n;
    // Least gap in ns; anything unlisted still needs the basic gap
    function automatic int gap_ns(input logic [6:0] w, input logic [6:0] r);
        if (w >= 7'h08 && w <= 7'h0F && r == 7'h20) return 135;
        if (w == 7'h15 && r == 7'h15) return 60;
        if (w == 7'h17 && r == 7'h15) return 90;
        if (w == 7'h17 && r == 7'h16) return 60;
        if (w == 7'h16 && r == 7'h15) return 180;
        if (w == 7'h16 && r == 7'h16) return 170;
        if (w == 7'h1A && r == 7'h15) return 90;
        if (w == 7'h1A && r == 7'h16) return 80;
        return 45;
    endfunction
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 32'h0;
    end
    // Byte order test is fixed; released bus never shows stale data
    assign word = (hb_addr[8:2] == 7'h19) ? BT_VAL : mem[hb_addr[8:2]];
    assign hb_data_in = rd_act ? (hb_addr[1] ? word[31:16] : word[15:0]) : idle_r;
    // Edges are seen one clock late on both ends, so elapsed time is exact
    always @(posedge clk) begin
        idle_r <= ~idle_r;
        wr_prev <= wr_act;
        rd_prev <= rd_act;
        if (wr_act) begin
            wa_r <= hb_addr;
            if (!hb_addr[1]) low_r <= hb_data_out;
            else if (hb_addr[8:2] != 7'h19) mem[hb_addr[8:2]] <= {hb_data_out, low_r};
        end
        // Only the final word of a tracked write opens the gap
        if (wr_prev && !wr_act && wa_r[1] && !exempt) begin
            last_w <= wa_r[8:2];
            t_w <= $realtime;
            wr_seen <= 1'b1;
        end
        if (rd_act && !rd_prev && !hb_addr[1]) begin
            if (hb_addr[8:2] == 7'h19) dummies <= dummies + 16'h0001;
            else if (wr_seen && !exempt && ($realtime - t_w) < gap_ns(last_w, hb_addr[8:2]))
                viol <= viol + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// file: testbench/host_write_read_spacing_test.sv
// Self-checking bench for the host write-read spacing controller
`timescale 1ns/100ps
`default_nettype none
module host_write_read_spacing_test;
    localparam logic [31:0] BT_VAL = 32'h1234ABCD; // Arbitrary byte order test pattern
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_index_reg = 1'b0;
    logic [8:0] req_addr = 9'h000;
    logic [31:0] req_wdata = 32'h00000000;
    logic dummy_read_en = 1'b0;
    logic mdl_ex = 1'b0; // Exempt flag of the access on the bus
    logic req_ready, rsp_valid, gap_stall, hb_cs_n, hb_rd_n, hb_wr_n, hb_data_oe;
    logic [31:0] rsp_rdata;
    logic [8:0] hb_addr;
    logic [15:0] hb_data_in, hb_data_out, viol, dummies;
    logic [31:0] ref_mem [128]; // Expected register contents
    int stall_n; // Gap stall cycles in the current read
    int oe_bad = 0; // Cycles with output enable off the write strobe
    logic [31:0] rd;
    logic [15:0] nd;
    integer seed = 32'h9032;
    int fails = 0;
    int compares = 0;
    int lat;
    int p;
    // Write/read pairs and their least gap in ns
    logic [8:0] pw [9] = '{9'h020, 9'h054, 9'h05C, 9'h05C, 9'h058, 9'h058, 9'h068, 9'h068, 9'h070};
    logic [8:0] pr [9] = '{9'h080, 9'h054, 9'h054, 9'h058, 9'h054, 9'h058, 9'h054, 9'h058, 9'h070};
    int pns [9] = '{135, 60, 90, 60, 180, 170, 90, 80, 45};
    hws_host_ctrl u_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
        .req_index_reg(req_index_reg), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .dummy_read_en(dummy_read_en), .gap_stall(gap_stall), .hb_addr(hb_addr),
        .hb_cs_n(hb_cs_n), .hb_rd_n(hb_rd_n), .hb_wr_n(hb_wr_n), .hb_data_in(hb_data_in),
        .hb_data_out(hb_data_out), .hb_data_oe(hb_data_oe));
    hws_dev_model #(.BT_VAL(BT_VAL)) u_dev (.clk(clk), .exempt(mdl_ex), .hb_addr(hb_addr),
        .hb_cs_n(hb_cs_n), .hb_rd_n(hb_rd_n), .hb_wr_n(hb_wr_n), .hb_data_out(hb_data_out),
        .hb_data_in(hb_data_in), .viol(viol), .dummies(dummies));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    // Counts stall cycles; a tracked read always passes one gap clock even when it need not wait
    always @(posedge clk) begin
        if (gap_stall === 1'b1) stall_n <= stall_n + 1;
        if (!srst && hb_data_oe !== (!hb_cs_n && !hb_wr_n)) oe_bad <= oe_bad + 1;
    end
    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask
    // Entered just after a rising edge; writes return one edge after accept, still back to back
    task automatic do_op(input logic wr, input logic ex, input logic [8:0] a, input logic [31:0] d);
        req_valid = 1'b1;
        req_write = wr;
        req_index_reg = ex;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        mdl_ex = ex;
        stall_n = 0;
        lat = 0;
        if (wr) begin
            ref_mem[a[8:2]] = d;
            @(posedge clk);
            #1;
        end else begin
            do begin
                @(negedge clk);
                lat++;
            end while (rsp_valid !== 1'b1 && lat < 300);
            check(lat < 300, "read timed out");
            rd = rsp_rdata;
            check(rd === (a[8:2] == 7'h19 ? BT_VAL : ref_mem[a[8:2]]), "read data");
            @(posedge clk);
            #1;
        end
    endtask
    // Hang guard
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 128; i++) ref_mem[i] = 32'h0;
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        // First read after reset has nothing to wait for
        do_op(1'b0, 1'b0, hws_pkg::A_IRQ_CONFIG, 32'h0);
        check(lat == 8 && stall_n <= 1, "first read waited");
        $display("test reset_read done");
        // Write then read at once, every pair, idle and dummy modes
        for (int m = 0; m < 2; m++) begin
            for (int q = 0; q < 9; q++) begin
                dummy_read_en = m[0];
                nd = dummies;
                do_op(1'b1, 1'b0, pw[q], $random(seed));
                do_op(1'b0, 1'b0, pr[q], 32'h0);
                check(viol === 16'h0, "read inside gap");
                check(lat <= 11 + 4 * ((pns[q] + 39) / 40), "gap wait too long");
                if (pns[q] > 120) begin
                    check(stall_n > 1 && lat > 8, "no stall");
                    check((dummies != nd) == m[0], "dummy read use");
                end
            end
        end
        $display("test pairs done");
        // Gap already met by idle time, and exempt accesses never wait
        do_op(1'b1, 1'b0, hws_pkg::A_INTERRUPT_STATUS, 32'h5A5A0F0F);
        repeat (8) @(posedge clk);
        #1;
        do_op(1'b0, 1'b0, hws_pkg::A_IRQ_CONFIG, 32'h0);
        check(lat == 8 && stall_n <= 1, "waited after gap");
        do_op(1'b1, 1'b0, hws_pkg::A_INTERRUPT_STATUS, 32'h0F0F1234);
        do_op(1'b0, 1'b1, hws_pkg::A_INTERRUPT_STATUS, 32'h0);
        check(lat == 7, "exempt read waited");
        repeat (8) @(posedge clk);
        #1;
        do_op(1'b1, 1'b1, 9'h0A0, 32'hC3C3_3C3C);
        do_op(1'b0, 1'b0, hws_pkg::A_IRQ_CONFIG, 32'h0);
        check(lat == 8 && stall_n <= 1, "exempt write opened gap");
        $display("test exempt done");
        // Byte order test read has no side effect
        nd = dummies;
        do_op(1'b0, 1'b0, hws_pkg::A_BYTE_ORDER_TEST, 32'h0);
        check(dummies === nd + 16'h0001 && lat == 8, "byte test read");
        $display("test byte_test done");
        // Random traffic over the gap registers
        for (int n = 0; n < 150; n++) begin
            dummy_read_en = 1'($random(seed));
            p = $unsigned($random(seed)) % 9;
            do_op(1'($random(seed)), ($random(seed) & 3) == 0, $random(seed) & 1 ? pw[p] : pr[p],
                $random(seed));
        end
        check(viol === 16'h0, "random read inside gap");
        check(oe_bad == 0, "output enable off the write strobe");
        $display("test random done");
        report_and_stop();
    end
endmodule
`default_nettype wire
